// >>> dbsp_buf.v
// two-entry valid/ready buffer between write capture and the array
`default_nettype none
`include "dbsp_regs.vh"

module dbsp_buf #(
	parameter WIDTH = 30,
	parameter DEPTH = `DBSP_BUF_DEPTH,
	parameter PTR_W = 1
) (
	// clock and reset
	input wire clock_i,
	input wire rstn_i,
	// fill side
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output reg in_ready_o,
	// drain side
	output reg out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);

	reg [WIDTH-1:0] slot [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr;
	reg [PTR_W-1:0] rd_ptr;
	reg [PTR_W:0] count;
	wire push;
	wire pop;
	wire [PTR_W:0] next_count;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign next_count = count + {{PTR_W{1'b0}}, push} -
		{{PTR_W{1'b0}}, pop};
	assign out_data_o = slot[rd_ptr];

	// ============================================================
	// storage
	always @(posedge clock_i) begin
		if (push)
			slot[wr_ptr] <= in_data_i;
	end

	// ============================================================
	// pointers and honest full / empty flags
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count <= {(PTR_W+1){1'b0}};
			in_ready_o <= `DBSP_ONE_BIT;
			out_valid_o <= `DBSP_RST_BIT;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH - 1) ? {PTR_W{1'b0}} :
					wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH - 1) ? {PTR_W{1'b0}} :
					rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			count <= next_count;
			in_ready_o <= (next_count != DEPTH);
			out_valid_o <= (next_count != {(PTR_W+1){1'b0}});
		end
	end

endmodule
`default_nettype wire

// >>> dbsp_host.sv
// host clock-pair model: runs the pair or parks it
`default_nettype none
module dbsp_host (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// park request, clock pair, phase
	input wire logic stop_i,
	output var logic k_o,
	output var logic kn_o,
	output var logic [1:0] ph_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// parking both high gives the cleanest restart
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{ph_o, k_o, kn_o} <= 4'h3;
		end else if (stop_i) begin
			{k_o, kn_o} <= 2'h3;
		end else begin
			ph_o <= ph_o + 2'h1;
			k_o <= ph_o[1] == ph_o[0];
			kn_o <= ph_o[1] != ph_o[0];
		end
	end
endmodule
`default_nettype wire

// >>> dbsp_regs.vh
// constants shared by the burst-of-two sram port and its buffer
`ifndef DBSP_REGS_VH
`define DBSP_REGS_VH

// ============================================================
// geometry
`define DBSP_LANE_W 9
`define DBSP_DATA_W 18
`define DBSP_LANES 2
`define DBSP_ADDR_W 8
`define DBSP_BUF_DEPTH 2

// ============================================================
// reset values
`define DBSP_RST_BIT 1'b0
`define DBSP_ONE_BIT 1'b1

// ============================================================
// one-hot states, write capture
`define DBSP_WR_IDLE 2'b01
`define DBSP_WR_BEAT1 2'b10

// ============================================================
// one-hot states, read launch
`define DBSP_RD_IDLE 3'b001
`define DBSP_RD_BEAT0 3'b010
`define DBSP_RD_BEAT1 3'b100

`endif

// >>> dbsp_sram_port.v
// burst-of-two ddr sram with separate read and write ports
//
// Functional notes
// - write: select on k, addr on kn
// - read data at k and kn of t+2
// - second beat goes to address plus one
// - data taken and launched on both phases
// - powers up deselected, outputs released
// - lane masks sampled with every beat
// - narrow part: two nine-bit lanes masked
// - narrow part: all masked writes nothing
// - wide part: four nine-bit lanes masked
// - wide part: all masked writes nothing
// - selects sampled on k, ports independent
`default_nettype none
`include "dbsp_regs.vh"

module dbsp_sram_port #(
	parameter LANE_W = `DBSP_LANE_W,
	parameter LANES = `DBSP_LANES,
	parameter DATA_W = `DBSP_DATA_W,
	parameter ADDR_W = `DBSP_ADDR_W
) (
	// system clock and reset
	input wire clock_i,
	input wire rstn_i,
	// memory clock pair, sampled on clock_i
	input wire k_i,
	input wire kn_i,
	// port selects
	input wire read_port_sel_n_i,
	input wire write_port_sel_n_i,
	// address and write data
	input wire [ADDR_W-1:0] addr_i,
	input wire [DATA_W-1:0] d_i,
	input wire [LANES-1:0] byte_lane_mask_n_i,
	// read data
	output reg [DATA_W-1:0] q_o,
	output reg q_oe_o,
	// write buffer has room
	output wire wr_ready_o
);

	localparam ENT_W = ADDR_W + DATA_W + LANES;
	localparam DEPTH = 1 << ADDR_W;

	// ============================================================
	// merge one beat into an array word, lane by lane
	function [DATA_W-1:0] lane_merge;
		input [DATA_W-1:0] old_word;
		input [DATA_W-1:0] new_word;
		input [LANES-1:0] mask_n;
		integer l;
		begin
			lane_merge = old_word;
			for (l = 0; l < LANES; l = l + 1) begin
				if (!mask_n[l])
					lane_merge[l*LANE_W +: LANE_W] =
						new_word[l*LANE_W +: LANE_W];
			end
		end
	endfunction

	// ============================================================
	// phase edge detection
	reg k_q;
	reg kn_q;
	wire k_rise;
	wire kn_rise;

	// no edge means capture and read logic hold: stopped clocks freeze them, staged writes still drain to the array
	assign k_rise = k_i & ~k_q;
	assign kn_rise = kn_i & ~kn_q;

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			k_q <= `DBSP_ONE_BIT;
			kn_q <= `DBSP_ONE_BIT;
		end else begin
			k_q <= k_i;
			kn_q <= kn_i;
		end
	end

	// ============================================================
	// array storage
	reg [DATA_W-1:0] mem [0:DEPTH-1];

	// ============================================================
	// write capture
	reg [1:0] wr_state;
	reg [DATA_W-1:0] wbeat0_d;
	reg [LANES-1:0] wbeat0_m;
	reg [ENT_W-1:0] st0;
	reg [ENT_W-1:0] st1;
	reg st0_v;
	reg st1_v;
	wire buf_in_ready;
	wire buf_in_valid;
	wire [ENT_W-1:0] buf_in_data;
	wire [ADDR_W-1:0] addr_next;

	assign addr_next = addr_i + {{(ADDR_W-1){1'b0}}, 1'b1};
	assign buf_in_valid = st0_v | st1_v;
	assign buf_in_data = st0_v ? st0 : st1;
	assign wr_ready_o = buf_in_ready;

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_state <= `DBSP_WR_IDLE;
			wbeat0_d <= {DATA_W{1'b0}};
			wbeat0_m <= {LANES{1'b1}};
			st0 <= {ENT_W{1'b0}};
			st1 <= {ENT_W{1'b0}};
			st0_v <= `DBSP_RST_BIT;
			st1_v <= `DBSP_RST_BIT;
		end else begin
			// hand the staged beats to the buffer, first beat first
			if (buf_in_ready && st0_v)
				st0_v <= `DBSP_RST_BIT;
			else if (buf_in_ready && st1_v)
				st1_v <= `DBSP_RST_BIT;
			case (wr_state)
			`DBSP_WR_IDLE: begin
				// deselected write port ignores data
				if (k_rise && !write_port_sel_n_i) begin
					wbeat0_d <= d_i;
					wbeat0_m <= byte_lane_mask_n_i;
					wr_state <= `DBSP_WR_BEAT1;
				end
			end
			`DBSP_WR_BEAT1: begin
				if (kn_rise) begin
					// address arrives with the second beat
					st0 <= {addr_i, wbeat0_d, wbeat0_m};
					st1 <= {addr_next, d_i, byte_lane_mask_n_i};
					// fully masked beat never reaches the array
					st0_v <= ~&wbeat0_m;
					st1_v <= ~&byte_lane_mask_n_i;
					wr_state <= `DBSP_WR_IDLE;
				end
			end
			default: wr_state <= `DBSP_WR_IDLE;
			endcase
		end
	end

	// ============================================================
	// write buffer and array drain
	wire drain_valid;
	wire drain_ready;
	wire [ENT_W-1:0] drain_data;
	wire [ADDR_W-1:0] drain_addr;
	wire [DATA_W-1:0] drain_d;
	wire [LANES-1:0] drain_m;
	wire rd_launch;

	// array write holds off while a read burst samples the array
	assign drain_ready = ~rd_launch;
	assign drain_addr = drain_data[ENT_W-1 -: ADDR_W];
	assign drain_d = drain_data[DATA_W+LANES-1 -: DATA_W];
	assign drain_m = drain_data[LANES-1:0];

	dbsp_buf #(
		.WIDTH(ENT_W),
		.DEPTH(`DBSP_BUF_DEPTH),
		.PTR_W(1)
	) u_wbuf (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.in_valid_i(buf_in_valid),
		.in_data_i(buf_in_data),
		.in_ready_o(buf_in_ready),
		.out_valid_o(drain_valid),
		.out_data_o(drain_data),
		.out_ready_i(drain_ready)
	);

	// masked lanes keep their old contents
	always @(posedge clock_i) begin
		if (drain_valid && drain_ready)
			mem[drain_addr] <= lane_merge(mem[drain_addr], drain_d, drain_m);
	end

	// ============================================================
	// read pipeline, two k edges of latency
	reg rd_v1;
	reg rd_v2;
	reg [ADDR_W-1:0] rd_a1;
	reg [ADDR_W-1:0] rd_a2;
	reg [2:0] rd_state;
	reg [DATA_W-1:0] word1;
	wire [ADDR_W-1:0] rd_a2_next;

	assign rd_launch = k_rise & rd_v2;
	assign rd_a2_next = rd_a2 + {{(ADDR_W-1){1'b0}}, 1'b1};

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_v1 <= `DBSP_RST_BIT;
			rd_v2 <= `DBSP_RST_BIT;
			rd_a1 <= {ADDR_W{1'b0}};
			rd_a2 <= {ADDR_W{1'b0}};
		end else if (k_rise) begin
			rd_v1 <= ~read_port_sel_n_i;
			rd_a1 <= addr_i;
			rd_v2 <= rd_v1;
			rd_a2 <= rd_a1;
		end
	end

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_state <= `DBSP_RD_IDLE;
			q_o <= {DATA_W{1'b0}};
			q_oe_o <= `DBSP_RST_BIT;
			word1 <= {DATA_W{1'b0}};
		end else begin
			case (rd_state)
			`DBSP_RD_IDLE, `DBSP_RD_BEAT1: begin
				if (rd_launch) begin
					q_o <= mem[rd_a2];
					word1 <= mem[rd_a2_next];
					q_oe_o <= `DBSP_ONE_BIT;
					rd_state <= `DBSP_RD_BEAT0;
				end else if (k_rise) begin
					// nothing pending: release after this k edge
					q_oe_o <= `DBSP_RST_BIT;
					rd_state <= `DBSP_RD_IDLE;
				end
			end
			`DBSP_RD_BEAT0: begin
				if (kn_rise) begin
					q_o <= word1;
					rd_state <= `DBSP_RD_BEAT1;
				end else if (rd_launch) begin
					q_o <= mem[rd_a2];
					word1 <= mem[rd_a2_next];
				end else if (k_rise) begin
					// k edge with no second beat seen: let the bus go
					q_oe_o <= `DBSP_RST_BIT;
					rd_state <= `DBSP_RD_IDLE;
				end
			end
			default: rd_state <= `DBSP_RD_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> dbsp_sram_port_assertions.sv
// concurrent checks on the sram port pins
`default_nettype none
module dbsp_chk #(parameter DATA_W = 18) (
	// clock, reset, inputs
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic k_i,
	input wire logic kn_i,
	input wire logic read_port_sel_n_i,
	// outputs
	input wire logic [DATA_W-1:0] q_o,
	input wire logic q_oe_o,
	input wire logic wr_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic kq, nq, p1, p2, ev, kr2, lq, seen;
	wire kr = k_i && !kq;
	wire nr = kn_i && !nq;
	// mirror of the read pipeline, to know launch edges
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{kq, nq, p1, p2, ev, kr2, lq, seen} <= 8'hc0;
		end else begin
			kq <= k_i;
			nq <= kn_i;
			ev <= kr || nr;
			kr2 <= kr;
			lq <= kr && p2;
			if (kr) {p2, p1} <= {p1, !read_port_sel_n_i};
			if (kr && !read_port_sel_n_i) seen <= 1'b1;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	q_edge_a: assert property (!$stable(q_o) |-> ev)
		else $error("q moved without edge");
	oe_on_k_a: assert property (!$stable(q_oe_o) |-> kr2)
		else $error("enable moved off k rise");
	rd_launch_a: assert property (kr && p2 |=> q_oe_o [*2])
		else $error("read word missing");
	rd_release_a: assert property (kr && !p2 |=> !q_oe_o)
		else $error("bus not released");
	oe_cause_a: assert property ($rose(q_oe_o) |-> lq)
		else $error("enable without read");
	boot_quiet_a: assert property ($rose(rstn_i) |-> !q_oe_o)
		else $error("driven at release");
	idle_dark_a: assert property (!seen |-> !q_oe_o)
		else $error("driven before read");
	room_back_a: assert property (!wr_ready_o |-> ##[1:8] wr_ready_o)
		else $error("buffer stuck full");
endmodule
bind dbsp_sram_port dbsp_chk #(.DATA_W(DATA_W)) i_dbsp_chk (
	.clock_i(clock_i), .rstn_i(rstn_i), .k_i(k_i), .kn_i(kn_i),
	.read_port_sel_n_i(read_port_sel_n_i), .q_o(q_o),
	.q_oe_o(q_oe_o), .wr_ready_o(wr_ready_o));
`default_nettype wire

// >>> dbsp_sram_port_bench.sv
// self-checking bench for the burst-of-two sram port
`default_nettype none
module dbsp_sram_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0, rstn_i = 1'b1, stop = 1'b0, rs = 1'b1;
	logic ws = 1'b1, k_i, kn_i, q_oe_o, wr_ready_o, kq, nq;
	logic p1, p2, l, wp, c0, c1, cz;
	logic [1:0] ph, m0, mk = 2'h0;
	logic [7:0] ad = 8'h00, wa, a1, a2, n = 8'h00;
	logic [17:0] d = 18'h0_0000, q_o, e0, e1, d0, mem [256];
	logic [31:0] s = 32'h59f0_3d40;
	int mode = 0, cyc = 0, bad_count = 0, compares = 0;
	dbsp_host i_dbsp_host (.clock_i(clock_i), .rstn_i(rstn_i),
		.stop_i(stop), .k_o(k_i), .kn_o(kn_i), .ph_o(ph));
	dbsp_sram_port i_dbsp_sram_port (.clock_i(clock_i), .rstn_i(rstn_i),
		.k_i(k_i), .kn_i(kn_i), .read_port_sel_n_i(rs),
		.write_port_sel_n_i(ws), .addr_i(ad), .d_i(d),
		.byte_lane_mask_n_i(mk), .q_o(q_o), .q_oe_o(q_oe_o),
		.wr_ready_o(wr_ready_o));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction
	function automatic logic [17:0] lane(input logic [17:0] o, w,
		input logic [1:0] m);
		lane = {m[1] ? o[17:9] : w[17:9], m[0] ? o[8:0] : w[8:0]};
	endfunction
	task chk(input logic [17:0] seen, want);
		compares++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task end_of_test();
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task run(input int m, c);
		mode = m;
		repeat (4 * c) @(negedge clock_i);
	endtask
	always #5 clock_i = !clock_i;
	// junk on every idle edge; commands only on the k and kn launch edges
	always @(posedge clock_i) begin
		s = xs(s);
		d <= s[17:0];
		mk <= mode < 2 ? 2'h0 : s[19:18];
		if (ph == 2'h3) begin
			rs <= !(mode == 3 || mode == 2 && s[30]);
			ws <= !(mode == 1 || mode == 2 && s[31]);
			ad <= mode == 3 ? n : {2'h2, s[5:0]};
			wa <= mode == 1 ? {n[6:0], 1'b1} : {2'h0, s[11:6]};
			n <= n + 8'h01;
		end else begin
			{rs, ws} <= s[29:28];
			ad <= ph == 2'h1 ? wa : s[27:20];
		end
	end
	// reference model, reacting to the same detected edges
	always @(posedge clock_i) begin
		if (!rstn_i) begin
			{kq, nq, p1, p2, l, wp, c0, c1, cz} <= 9'h180;
		end else begin
			if (c0) chk(q_o, e0);
			if (c0) chk(q_oe_o, 18'h0_0001);
			if (c1) chk(q_o, e1);
			if (cz) chk(q_oe_o, 18'h0_0000);
			{c0, c1, cz} <= 3'h0;
			kq <= k_i;
			nq <= kn_i;
			if (k_i && !kq) begin
				{p2, a2, p1, a1} <= {p1, a1, !rs, ad};
				{l, c0, cz} <= {p2, p2, !p2};
				e0 <= mem[a2];
				e1 <= mem[a2 + 8'h01];
				// a k edge while a write waits for its second beat is ignored
				if (!ws && !wp) {wp, d0, m0} <= {1'b1, d, mk};
			end
			if (kn_i && !nq && l) c1 <= 1'b1;
			if (kn_i && !nq && wp) begin
				mem[ad] <= lane(mem[ad], d0, m0);
				mem[ad + 8'h01] <= lane(mem[ad + 8'h01], d, mk);
				wp <= 1'b0;
			end
		end
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		#1 rstn_i = 1'b0;
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(negedge clock_i);
		chk(q_oe_o, 18'h0_0000);
		chk(wr_ready_o, 18'h0_0001);
		run(1, 128);
		run(0, 8);
		stop = 1'b1;
		run(0, 6);
		stop = 1'b0;
		run(0, 4);
		run(2, 200);
		run(0, 4);
		run(3, 256);
		run(0, 4);
		end_of_test();
	end
endmodule
`default_nettype wire

// >>> dummy_unused_guard.v
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire
